// file: design/pbw_wiper_ctrl.sv
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module pbw_wiper_ctrl #(
  parameter int TICK_CYCLES = pbw_pkg::PBW_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // contact inputs, low while closed
  input wire logic [3:0] contact_n,
  // power-up straps
  input wire logic mode_sel_in,
  // serial port
  input wire logic serial_en_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  // register bus
  input wire pbw_pkg::pbw_axi_req_t axi_req,
  output pbw_pkg::pbw_axi_rsp_t axi_rsp,
  // wiper positions
  output logic [5:0] wiper0_pos,
  output logic [5:0] wiper1_pos
);

  // every flip-flop of the block
  typedef struct packed {
    logic [15:0] tick_cnt;
    logic tick;
    logic [9:0] boot_cnt;
    logic ready;
    logic strap_done;
    logic stereo;
    logic single;
    logic [3:0] filt;
    logic [3:0] stab;
    logic [3:0][9:0] hold;
    logic [3:0][9:0] idle;
    logic [3:0] dir;
    logic [5:0] w0;
    logic [5:0] w1;
    logic [5:0] bal_ref;
    logic bal_valid;
    logic sclk_prev;
    logic sen_prev;
    logic [15:0] sr;
    logic pb_en;
    logic [pbw_pkg::PBW_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    pbw_pkg::pbw_axi_rsp_t rsp;
  } pbw_state_t;

  pbw_state_t q; // registered state
  pbw_state_t d; // next state
  logic [3:0] press; // debounced closure seen this cycle
  logic [3:0] rpt; // auto-repeat step due
  logic [3:0] step; // step accepted for the wiper logic
  logic [3:0] ignore; // channel currently has no effect
  logic busy; // serial frame in progress
  logic up; // direction or side of the current step
  logic [5:0] pos; // scratch wiper position
  logic [5:0] lo; // nearer-high wiper of the pair
  logic [5:0] hi; // nearer-low wiper of the pair
  logic [31:0] rdat; // read data being built

  // register index of a bus address; unmapped gives 2'h3
  function automatic logic [1:0] pbw_reg_sel(input logic [pbw_pkg::PBW_AW-1:0] a);
    if (a == pbw_pkg::PBW_OFS_POSITION)
    begin
      pbw_reg_sel = 2'h0;
    end
    else if (a == pbw_pkg::PBW_OFS_CONTROL)
    begin
      pbw_reg_sel = 2'h1;
    end
    else
    begin
      pbw_reg_sel = 2'h3;
    end
  endfunction

  // next state of the whole block
  always_comb
  begin
    d = q;
    press = '0;
    rpt = '0;
    step = '0;
    ignore = '0;
    up = 1'b0;
    pos = '0;
    lo = '0;
    hi = '0;
    rdat = '0;

    // one-millisecond tick from the system clock
    d.tick = 1'b0;
    if (q.tick_cnt == 16'(TICK_CYCLES - 1))
    begin
      d.tick_cnt = '0;
      d.tick = 1'b1;
    end
    else
    begin
      d.tick_cnt = q.tick_cnt + 16'h0001;
    end

    // straps caught on the first clock after reset release
    if (!q.strap_done)
    begin
      d.strap_done = 1'b1;
      d.stereo = ~mode_sel_in;
      d.single = contact_n[2] & contact_n[3];
    end

    // contacts stay dead until the start-up delay has run
    if (q.tick && !q.ready)
    begin
      if (q.boot_cnt == pbw_pkg::PBW_BOOT_TICKS - 10'h001)
      begin
        d.ready = 1'b1;
      end
      d.boot_cnt = q.boot_cnt + 10'h001;
    end

    // the load cycle after the frame also counts as busy
    busy = serial_en_in | q.sen_prev;

    // per-channel debounce, hold timing and idle timing
    for (int i = 0; i < pbw_pkg::PBW_NCH; i++)
    begin
      // a level must differ on two ticks in a row to be taken
      if (q.tick)
      begin
        if (contact_n[i] != q.filt[i])
        begin
          if (q.stab[i])
          begin
            d.filt[i] = contact_n[i];
            d.stab[i] = 1'b0;
          end
          else
          begin
            d.stab[i] = 1'b1;
          end
        end
        else
        begin
          d.stab[i] = 1'b0;
        end
      end
      press[i] = q.filt[i] & ~d.filt[i];
      // hold counter: first step at press, then repeat after the hold
      if (press[i])
      begin
        d.hold[i] = '0;
      end
      else if (q.tick && !q.filt[i])
      begin
        if (q.hold[i] + 10'h001 == pbw_pkg::PBW_HOLD_TICKS)
        begin
          rpt[i] = 1'b1;
          d.hold[i] = pbw_pkg::PBW_HOLD_TICKS - pbw_pkg::PBW_REPEAT_TICKS;
        end
        else
        begin
          d.hold[i] = q.hold[i] + 10'h001;
        end
      end
      // idle counter saturates once the input has rested long enough
      if (press[i])
      begin
        d.idle[i] = '0;
      end
      else if (q.tick && q.filt[i] && q.idle[i] != pbw_pkg::PBW_IDLE_TICKS)
      begin
        d.idle[i] = q.idle[i] + 10'h001;
      end
      // the tied-high inputs have no function in single mode
      ignore[i] = !q.ready || !q.pb_en || busy || (q.single && i >= 2);
      step[i] = (press[i] | rpt[i]) & ~ignore[i];
      // single mode: a new burst after a rest reverses direction
      if (press[i] && !ignore[i] && q.single && q.idle[i] == pbw_pkg::PBW_IDLE_TICKS)
      begin
        d.dir[i] = ~q.dir[i];
      end
    end

    // wiper moves, channels taken in index order
    for (int i = 0; i < pbw_pkg::PBW_NCH; i++)
    begin
      if (step[i])
      begin
        up = q.single ? d.dir[i] : (i < 2);
        if (!q.stereo)
        begin
          // independent: even channels drive wiper 0, odd wiper 1
          pos = (i % 2 == 0) ? d.w0 : d.w1;
          if (up && pos != pbw_pkg::PBW_POS_TOP)
          begin
            pos = pos - 6'h01;
          end
          else if (!up && pos != pbw_pkg::PBW_POS_BOTTOM)
          begin
            pos = pos + 6'h01;
          end
          if (i % 2 == 0)
          begin
            d.w0 = pos;
          end
          else
          begin
            d.w1 = pos;
          end
          if (q.single && pbw_pkg::pbw_at_end(pos))
          begin
            d.dir[i] = ~d.dir[i];
          end
        end
        else if (i % 2 == 0)
        begin
          // volume: move the pair only if neither leaves the array
          lo = pbw_pkg::pbw_min(d.w0, d.w1);
          hi = pbw_pkg::pbw_max(d.w0, d.w1);
          if (up && lo != pbw_pkg::PBW_POS_TOP)
          begin
            d.w0 = d.w0 - 6'h01;
            d.w1 = d.w1 - 6'h01;
            lo = lo - 6'h01;
          end
          else if (!up && hi != pbw_pkg::PBW_POS_BOTTOM)
          begin
            d.w0 = d.w0 + 6'h01;
            d.w1 = d.w1 + 6'h01;
            hi = hi + 6'h01;
          end
          // a volume move ends the current balance session
          d.bal_valid = 1'b0;
          if (q.single && ((up && lo == pbw_pkg::PBW_POS_TOP) ||
                           (!up && hi == pbw_pkg::PBW_POS_BOTTOM)))
          begin
            d.dir[i] = ~d.dir[i];
          end
        end
        else if (!(d.w0 == pbw_pkg::PBW_POS_BOTTOM && d.w1 == pbw_pkg::PBW_POS_BOTTOM))
        begin
          // balance: reference is the nearer-high wiper at first use
          if (!d.bal_valid)
          begin
            d.bal_ref = pbw_pkg::pbw_min(d.w0, d.w1);
            d.bal_valid = 1'b1;
          end
          if (up)
          begin
            if (d.w0 > d.bal_ref)
            begin
              d.w0 = d.w0 - 6'h01;
            end
            else if (d.w1 != pbw_pkg::PBW_POS_BOTTOM)
            begin
              d.w1 = d.w1 + 6'h01;
            end
          end
          else
          begin
            if (d.w1 > d.bal_ref)
            begin
              d.w1 = d.w1 - 6'h01;
            end
            else if (d.w0 != pbw_pkg::PBW_POS_BOTTOM)
            begin
              d.w0 = d.w0 + 6'h01;
            end
          end
        end
      end
    end

    // serial port: shift lsb first on rising clock, load on enable fall
    d.sclk_prev = serial_clk_in;
    d.sen_prev = serial_en_in;
    if (serial_en_in && serial_clk_in && !q.sclk_prev)
    begin
      d.sr = {serial_data_in, q.sr[pbw_pkg::PBW_SER_BITS-1:1]};
    end
    if (!serial_en_in && q.sen_prev)
    begin
      d.w0 = q.sr[pbw_pkg::PBW_SER_W0_LSB +: 6];
      d.w1 = q.sr[pbw_pkg::PBW_SER_W1_LSB +: 6];
      d.bal_valid = 1'b0;
    end

    // write address and data are taken in either order
    if (q.rsp.awready && axi_req.awvalid)
    begin
      d.awaddr = axi_req.awaddr;
      d.rsp.awready = 1'b0;
    end
    if (q.rsp.wready && axi_req.wvalid)
    begin
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
      d.rsp.wready = 1'b0;
    end
    // both halves held: perform the write and answer
    if (!q.rsp.awready && !q.rsp.wready && !q.rsp.bvalid)
    begin
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = pbw_pkg::PBW_RESP_OKAY;
      case (pbw_reg_sel(q.awaddr))
        2'h0:
        begin
          // position register is read-only; writes are dropped
        end
        2'h1:
        begin
          if (q.wstrb[0])
          begin
            d.pb_en = q.wdata[pbw_pkg::PBW_F_ENABLE];
          end
        end
        default:
        begin
          d.rsp.bresp = pbw_pkg::PBW_RESP_SLVERR;
        end
      endcase
    end
    if (q.rsp.bvalid && axi_req.bready)
    begin
      d.rsp.bvalid = 1'b0;
      d.rsp.awready = 1'b1;
      d.rsp.wready = 1'b1;
    end

    // read: one cycle from address to data
    if (q.rsp.arready && axi_req.arvalid)
    begin
      d.rsp.arready = 1'b0;
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp = pbw_pkg::PBW_RESP_OKAY;
      case (pbw_reg_sel(axi_req.araddr))
        2'h0:
        begin
          rdat[pbw_pkg::PBW_F_W0_LSB +: 6] = q.w0;
          rdat[pbw_pkg::PBW_F_W1_LSB +: 6] = q.w1;
          rdat[pbw_pkg::PBW_F_STEREO] = q.stereo;
          rdat[pbw_pkg::PBW_F_SINGLE] = q.single;
          rdat[pbw_pkg::PBW_F_BUSY] = busy;
          rdat[pbw_pkg::PBW_F_READY] = q.ready;
        end
        2'h1:
        begin
          rdat[pbw_pkg::PBW_F_ENABLE] = q.pb_en;
        end
        default:
        begin
          d.rsp.rresp = pbw_pkg::PBW_RESP_SLVERR;
        end
      endcase
      d.rsp.rdata = rdat;
    end
    if (q.rsp.rvalid && axi_req.rready)
    begin
      d.rsp.rvalid = 1'b0;
      d.rsp.arready = 1'b1;
    end
  end

  // state register; only the non-zero reset values are listed
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.filt <= pbw_pkg::PBW_CONTACT_IDLE;
      q.w0 <= pbw_pkg::PBW_POS_RESET;
      q.w1 <= pbw_pkg::PBW_POS_RESET;
      q.pb_en <= pbw_pkg::PBW_ENABLE_RESET;
      q.rsp.awready <= 1'b1;
      q.rsp.wready <= 1'b1;
      q.rsp.arready <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign axi_rsp = q.rsp;
  assign wiper0_pos = q.w0;
  assign wiper1_pos = q.w1;

endmodule

// file: design/pbw_pkg.sv
package pbw_pkg;
  // timing base
  localparam int PBW_CLK_MHZ = 50;
  localparam int PBW_TICK_US = 1000;
  localparam int PBW_TICK_CYCLES = PBW_CLK_MHZ * PBW_TICK_US;
  localparam int PBW_BOOT_MS = 50;
  localparam int PBW_HOLD_MS = 1000;
  localparam int PBW_REPEAT_MS = 100;
  localparam int PBW_IDLE_MS = 1000;
  localparam logic [9:0] PBW_BOOT_TICKS = 10'(PBW_BOOT_MS * 1000 / PBW_TICK_US);
  localparam logic [9:0] PBW_HOLD_TICKS = 10'(PBW_HOLD_MS * 1000 / PBW_TICK_US);
  localparam logic [9:0] PBW_REPEAT_TICKS = 10'(PBW_REPEAT_MS * 1000 / PBW_TICK_US);
  localparam logic [9:0] PBW_IDLE_TICKS = 10'(PBW_IDLE_MS * 1000 / PBW_TICK_US);
  // wiper positions
  localparam logic [5:0] PBW_POS_TOP = 6'h00;
  localparam logic [5:0] PBW_POS_BOTTOM = 6'h3f;
  localparam logic [5:0] PBW_POS_RESET = 6'h3f;
  // contact channels: up0/volume-raise, up1/balance-0, down0/volume-lower, down1/balance-1
  localparam int PBW_NCH = 4;
  localparam logic [3:0] PBW_CONTACT_IDLE = 4'hf;
  // serial frame layout
  localparam int PBW_SER_BITS = 16;
  localparam int PBW_SER_W0_LSB = 0;
  localparam int PBW_SER_W1_LSB = 8;
  // register map
  localparam int PBW_AW = 4;
  localparam logic [3:0] PBW_OFS_POSITION = 4'h0;
  localparam logic [3:0] PBW_OFS_CONTROL = 4'h4;
  localparam int PBW_F_W0_LSB = 0;
  localparam int PBW_F_W1_LSB = 8;
  localparam int PBW_F_STEREO = 16;
  localparam int PBW_F_SINGLE = 17;
  localparam int PBW_F_BUSY = 18;
  localparam int PBW_F_READY = 19;
  localparam int PBW_F_ENABLE = 0;
  localparam logic PBW_ENABLE_RESET = 1'b1;
  localparam logic [1:0] PBW_RESP_OKAY = 2'h0;
  localparam logic [1:0] PBW_RESP_SLVERR = 2'h2;
  // axi4-lite request from master
  typedef struct packed {
    logic awvalid;
    logic [PBW_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [PBW_AW-1:0] araddr;
    logic rready;
  } pbw_axi_req_t;
  // axi4-lite answer from slave
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pbw_axi_rsp_t;
  // smaller of two positions
  function automatic logic [5:0] pbw_min(input logic [5:0] a, input logic [5:0] b);
    pbw_min = (a < b) ? a : b;
  endfunction
  // larger of two positions
  function automatic logic [5:0] pbw_max(input logic [5:0] a, input logic [5:0] b);
    pbw_max = (a > b) ? a : b;
  endfunction
  // position sits at either end of the array
  function automatic logic pbw_at_end(input logic [5:0] p);
    pbw_at_end = (p == PBW_POS_TOP) || (p == PBW_POS_BOTTOM);
  endfunction
endpackage

// file: dv/pbw_contact_model.sv
`timescale 1ns/1ps
// pushbuttons to ground with pull-ups; contacts chatter when they close
module pbw_contact_model #(
  parameter int TICK = 10
) (
  // clock
  input wire logic clk,
  // holds down-0 closed through power-up so dual mode is strapped
  input wire logic dual_strap,
  // contact lines, low while closed
  output logic [3:0] contact_n
);
  logic [3:0] shut = 4'h0; // contacts held closed
  logic [3:0] bnc = 4'h0; // chatter on closing contacts
  // an open contact floats to its pull-up
  assign contact_n = ~(shut | {1'b0, dual_strap, 2'b00}) ^ bnc;
  // close one contact for lo cycles, then leave it open for hi cycles
  task automatic press(input int ch, input int lo, input int hi, input bit rough);
    @(posedge clk);
    shut[ch] <= 1'b1;
    // chatter stays under one sample tick, so at most one sample is wrong
    for (int i = 0; i < TICK / 2; i++)
    begin
      if (rough)
        bnc[ch] <= 1'($urandom);
      @(posedge clk);
    end
    bnc[ch] <= 1'b0;
    repeat (lo) @(posedge clk);
    shut[ch] <= 1'b0;
    // the open time decides whether two closures count apart
    repeat (hi) @(posedge clk);
  endtask
endmodule

// file: dv/pbw_wiper_ctrl_monitor.sv
`timescale 1ns/1ps
// watches wiper moves against contacts, straps and the serial port
module pbw_wiper_ctrl_monitor #(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs watched
  input wire logic [3:0] contact_n,
  input wire logic mode_sel_in,
  input wire logic serial_en_in,
  // wipers
  input wire logic [5:0] wiper0_pos,
  input wire logic [5:0] wiper1_pos
);
  logic [2:0] sen_q; // serial enable history
  logic boot_q; // reset seen last edge
  logic stereo_q; // strapped mode
  int cnt_q; // cycles since release
  logic ser; // a serial load may still land
  assign ser = serial_en_in | (|sen_q);
  // helper state; the strap is taken as the design takes it
  always_ff @(posedge clk)
  begin
    sen_q <= rst ? 3'h0 : {sen_q[1:0], serial_en_in};
    boot_q <= rst;
    cnt_q <= rst ? 0 : cnt_q + 1;
    if (boot_q)
      stereo_q <= !mode_sel_in;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_reset_pos;
    $fell(rst) |-> wiper0_pos == 6'h3f && wiper1_pos == 6'h3f;
  endproperty
  a_reset_pos: assert property (p_reset_pos) else $error("wipers not at bottom");
  property p_one_step;
    !ser && $changed(wiper0_pos) |-> wiper0_pos - $past(wiper0_pos) == 6'h01
      || $past(wiper0_pos) - wiper0_pos == 6'h01;
  endproperty
  a_one_step: assert property (p_one_step) else $error("wiper 0 jumped");
  property p_serial_first;
    serial_en_in && sen_q[0] && sen_q[1] |-> $stable(wiper0_pos) && $stable(wiper1_pos);
  endproperty
  a_serial_first: assert property (p_serial_first) else $error("step during serial");
  property p_boot_quiet;
    cnt_q < 50 * TICK_CYCLES && !ser |-> $stable(wiper0_pos) && $stable(wiper1_pos);
  endproperty
  a_boot_quiet: assert property (p_boot_quiet) else $error("step before start-up");
  property p_own_wiper;
    !stereo_q && !ser |-> !($changed(wiper0_pos) && $past(contact_n[0]) && $past(contact_n[2]))
      && !($changed(wiper1_pos) && $past(contact_n[1]) && $past(contact_n[3]));
  endproperty
  a_own_wiper: assert property (p_own_wiper) else $error("wiper moved by other input");
  property p_bottom_hold;
    stereo_q && !ser && $past(wiper0_pos) == 6'h3f && $past(wiper1_pos) == 6'h3f
      && $past(contact_n[0]) |-> $stable(wiper0_pos) && $stable(wiper1_pos);
  endproperty
  a_bottom_hold: assert property (p_bottom_hold) else $error("balance moved bottom");
  property p_keep_offset;
    stereo_q && !ser && $past(contact_n[1]) && $past(contact_n[3])
      |-> wiper0_pos - wiper1_pos == $past(wiper0_pos) - $past(wiper1_pos);
  endproperty
  a_keep_offset: assert property (p_keep_offset) else $error("volume lost offset");
  property p_no_wrap;
    !ser |-> !(wiper0_pos == 6'h3f && $past(wiper0_pos) == 6'h00)
      && !(wiper0_pos == 6'h00 && $past(wiper0_pos) == 6'h3f);
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("wiper 0 wrapped");
  // main scenarios reached
  cover property (stereo_q && $changed(wiper0_pos) && $changed(wiper1_pos));
  cover property ($fell(serial_en_in));
  cover property (!stereo_q && $changed(wiper1_pos));
endmodule
bind pbw_wiper_ctrl pbw_wiper_ctrl_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_pbw_wiper_ctrl_monitor (
  .clk(clk), .rst(rst), .contact_n(contact_n), .mode_sel_in(mode_sel_in),
  .serial_en_in(serial_en_in), .wiper0_pos(wiper0_pos), .wiper1_pos(wiper1_pos));

// file: dv/tb_pbw_wiper_ctrl.sv
`timescale 1ns/1ps
// drives contacts, serial port and register bus; scores every wiper move
module tb_pbw_wiper_ctrl;
  localparam int TK = 10; // clocks per ms, keeps second-long holds short
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mode_sel_in = 1'b1;
  logic dual_strap = 1'b1;
  logic serial_en_in = 1'b0;
  logic serial_clk_in = 1'b0;
  logic serial_data_in = 1'b0;
  pbw_pkg::pbw_axi_req_t req = '0;
  pbw_pkg::pbw_axi_rsp_t rsp;
  logic [3:0] contact_n;
  logic [5:0] wiper0_pos;
  logic [5:0] wiper1_pos;
  logic [11:0] exp_q[$]; // wiper pairs still due
  logic [11:0] last; // pair last seen
  logic [31:0] want; // pair due now
  int mismatches = 0;
  int checked = 0;
  always #10 clk = ~clk;
  pbw_wiper_ctrl #(.TICK_CYCLES(TK)) i_pbw_wiper_ctrl (.clk(clk), .rst(rst),
    .contact_n(contact_n), .mode_sel_in(mode_sel_in), .serial_en_in(serial_en_in),
    .serial_clk_in(serial_clk_in), .serial_data_in(serial_data_in), .axi_req(req),
    .axi_rsp(rsp), .wiper0_pos(wiper0_pos), .wiper1_pos(wiper1_pos));
  pbw_contact_model #(.TICK(TK)) i_pbw_contact_model (.clk(clk), .dual_strap(dual_strap),
    .contact_n(contact_n));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // record the pair the next move must give
  task automatic note(input logic [5:0] a, input logic [5:0] b);
    exp_q.push_back({a, b});
  endtask
  // every move takes the oldest note; a move with none noted fails
  always @(negedge clk)
  begin
    if (rst)
      last = {wiper0_pos, wiper1_pos};
    else if ({wiper0_pos, wiper1_pos} !== last)
    begin
      last = {wiper0_pos, wiper1_pos};
      want = (exp_q.size() > 0) ? 32'(exp_q.pop_front()) : 32'hffff_ffff;
      check("wiper pair", 32'(last), want);
    end
  end
  // one 5 ms closure, then all notes must have landed
  task automatic pb(input int ch);
    i_pbw_contact_model.press(ch, 5 * TK, 5 * TK, 1'b1);
    check("pending notes", exp_q.size(), 0);
  endtask
  // reset with straps held through the first edge after release
  task automatic boot(input logic mode, input logic dual);
    rst <= 1'b1;
    mode_sel_in <= mode;
    dual_strap <= dual;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    exp_q.delete();
    repeat (20) @(posedge clk);
    dual_strap <= 1'b0;
    check("reset wipers", 32'({wiper0_pos, wiper1_pos}), 32'hfff);
  endtask
  // 16-bit frame lsb first; the clock stands low outside frames
  // both wipers load in one cycle when enable falls, so one move is due
  task automatic ser(input logic [15:0] v);
    note(v[5:0], v[13:8]);
    serial_en_in <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      serial_data_in <= v[i];
      repeat (2) @(posedge clk);
      serial_clk_in <= 1'b1;
      repeat (2) @(posedge clk);
      serial_clk_in <= 1'b0;
    end
    @(posedge clk);
    serial_en_in <= 1'b0;
    serial_data_in <= ~serial_data_in;
    repeat (4) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
      n++;
    end
    while (!rsp.bvalid && n < 200);
    req.bready <= 1'b0;
    check("bvalid", 32'(rsp.bvalid), 32'h1);
    check("bresp", 32'(rsp.bresp), 32'(r));
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rsp.arready)
        req.arvalid <= 1'b0;
      n++;
    end
    while (!rsp.rvalid && n < 200);
    req.rready <= 1'b0;
    check("rvalid", 32'(rsp.rvalid), 32'h1);
    check("rdata", rsp.rdata, d);
    check("rresp", 32'(rsp.rresp), 32'(r));
  endtask
  // watchdog: the tests need about 52000 cycles
  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    final_report();
  end
  initial
  begin
    void'($urandom(32'he9ef));
    boot(1'b1, 1'b1);
    pb(0);
    rd(4'h0, 32'h0000_3f3f, 2'h0);
    repeat (50 * TK) @(posedge clk);
    rd(4'h0, 32'h0008_3f3f, 2'h0);
    note(6'h3e, 6'h3f);
    pb(0);
    note(6'h3e, 6'h3e);
    pb(1);
    note(6'h3e, 6'h3f);
    pb(3);
    pb(3);
    note(6'h3d, 6'h3f);
    i_pbw_contact_model.press(0, 5 * TK, 4, 1'b0);
    pb(0);
    for (int k = 1; k <= 5; k++)
      note(6'h3d, 6'h3f - 6'(k));
    i_pbw_contact_model.press(1, 1350 * TK, 5 * TK, 1'b1);
    check("pending notes", exp_q.size(), 0);
    wr(pbw_pkg::PBW_OFS_CONTROL, 32'h0, 2'h0);
    rd(pbw_pkg::PBW_OFS_CONTROL, 32'h0, 2'h0);
    pb(0);
    wr(pbw_pkg::PBW_OFS_CONTROL, 32'h1, 2'h0);
    rd(4'h8, 32'h0, 2'h2);
    wr(4'hc, 32'h1, 2'h2);
    ser(16'h2028);
    fork
      ser(16'h1a1e);
      i_pbw_contact_model.press(0, 3 * TK, 5 * TK, 1'b1);
    join
    boot(1'b0, 1'b1);
    repeat (60 * TK) @(posedge clk);
    rd(4'h0, 32'h0009_3f3f, 2'h0);
    pb(1);
    ser(16'h2028);
    note(6'h27, 6'h1f);
    pb(0);
    note(6'h28, 6'h20);
    pb(2);
    ser(16'h1e1f);
    note(6'h1e, 6'h1e);
    pb(1);
    note(6'h1e, 6'h1f);
    pb(1);
    ser(16'h0005);
    pb(0);
    ser(16'h3f0a);
    pb(1);
    note(6'h0a, 6'h3e);
    pb(3);
    boot(1'b1, 1'b0);
    repeat (1100 * TK) @(posedge clk);
    note(6'h3e, 6'h3f);
    pb(0);
    note(6'h3d, 6'h3f);
    pb(0);
    rd(4'h0, 32'h000a_3f3d, 2'h0);
    repeat (1100 * TK) @(posedge clk);
    note(6'h3e, 6'h3f);
    pb(0);
    // reaching the bottom turns the single button back upward
    note(6'h3f, 6'h3f);
    pb(0);
    note(6'h3e, 6'h3f);
    pb(0);
    pb(2);
    // stereo single: volume reverses at the end, balance side toggles after rest
    boot(1'b0, 1'b0);
    repeat (60 * TK) @(posedge clk);
    rd(4'h0, 32'h000b_3f3f, 2'h0);
    ser(16'h3e3d);
    note(6'h3e, 6'h3f);
    pb(0);
    note(6'h3d, 6'h3e);
    pb(0);
    note(6'h3d, 6'h3d);
    pb(1);
    repeat (1100 * TK) @(posedge clk);
    note(6'h3d, 6'h3e);
    pb(1);
    final_report();
  end
endmodule
